/* core/sdorsp_pkg.sv */
// Shared constants for the expedited request responder
package sdorsp_pkg;
   // Frame identifiers and length
   localparam logic [10:0] REQ_BASE = 11'h600;
   localparam logic [10:0] RSP_BASE = 11'h580;
   localparam logic [3:0] FRAME_DLC = 4'h8;
   // Command byte layout
   localparam int CS_MSB = 7;
   localparam int CS_LSB = 4;
   localparam int UNUSED_MSB = 3;
   localparam int UNUSED_LSB = 2;
   // Command specifier values
   localparam logic [3:0] CS_WRITE = 4'h2;
   localparam logic [3:0] CS_QUERY = 4'h4;
   localparam logic [3:0] CS_WRITE_OK = 4'h6;
   localparam logic [3:0] CS_ERROR = 4'h8;
   // Unused-byte counts
   localparam logic [1:0] UNUSED_ONE_BYTE = 2'h3;
   localparam logic [1:0] UNUSED_U16 = 2'h2;
   localparam logic [1:0] UNUSED_NONE = 2'h0;
   // Supported objects
   localparam logic [15:0] HALT_INDEX = 16'h200C;
   localparam logic [7:0] HALT_SUB = 8'h00;
   localparam logic [7:0] HALT_ON = 8'h01;
   localparam logic [7:0] HALT_OFF = 8'h00;
   localparam logic [15:0] VOLT_INDEX = 16'h210D;
   localparam logic [7:0] VOLT_SUB = 8'h02;
   // Register byte addresses
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_COUNT = 8'h08;
   // Register field positions and reset values
   localparam int CTRL_EN_BIT = 8;
   localparam int STATUS_HALT_BIT = 0;
   localparam logic [6:0] NODE_ID_RST = 7'h01;
   localparam logic CTRL_EN_RST = 1'b1;
   // Responder states, Gray along idle-decode-send
   typedef enum logic [1:0] {
      SDORSP_IDLE = 2'b00,
      SDORSP_DECODE = 2'b01,
      SDORSP_SEND = 2'b11
   } sdorsp_state_e;
endpackage

/* core/sdorsp_cfg_if.sv */
// Interface between the responder core and its register file
`timescale 1ns/1ns
`default_nettype none
interface sdorsp_cfg_if;
   logic [6:0] node_id;  // Own node identifier
   logic enable;         // Responder enable
   logic halt;           // Emergency halt state
   logic halt_set;       // One-cycle request to raise halt
   logic req_inc;        // One-cycle accepted-request count
   logic err_inc;        // One-cycle error-reply count
   modport regs (output node_id, output enable, output halt, input halt_set, input req_inc, input err_inc);
   modport core (input node_id, input enable, input halt, output halt_set, output req_inc, output err_inc);
endinterface
`default_nettype wire

/* core/sdorsp_wb_regs.sv */
// Wishbone classic register file of the responder
`timescale 1ns/1ns
`default_nettype none
module sdorsp_wb_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   sdorsp_cfg_if.regs cfg
);
   logic ack_reg, ack_next;            // Bus answer
   logic [31:0] dat_reg, dat_next;     // Read data
   logic [6:0] node_reg, node_next;    // Node identifier
   logic en_reg, en_next;              // Enable
   logic halt_reg, halt_next;          // Sticky halt
   logic [15:0] req_reg, req_next;     // Accepted requests
   logic [15:0] err_reg, err_next;     // Error replies
   logic wr;                           // Write commits on the acked edge

   // Next values for bus and registers
   always_comb begin
      ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
      dat_next = dat_reg;
      wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
      node_next = node_reg;
      en_next = en_reg;
      req_next = req_reg + {15'h0000, cfg.req_inc};
      err_next = err_reg + {15'h0000, cfg.err_inc};
      halt_next = halt_reg;
      // Read data is latched with ack so it is steady when sampled
      if (ack_next) begin
         unique case (wb_adr_i)
            sdorsp_pkg::ADR_CTRL: dat_next = {23'h000000, en_reg, 1'b0, node_reg};
            sdorsp_pkg::ADR_STATUS: dat_next = {31'h00000000, halt_reg};
            sdorsp_pkg::ADR_COUNT: dat_next = {err_reg, req_reg};
            default: dat_next = 32'h00000000; // Unmapped reads as zero
         endcase
      end
      if (wr && wb_adr_i == sdorsp_pkg::ADR_CTRL) begin
         if (wb_sel_i[0]) begin
            node_next = wb_dat_i[6:0];
         end
         if (wb_sel_i[1]) begin
            en_next = wb_dat_i[sdorsp_pkg::CTRL_EN_BIT];
         end
      end
      // Write one clears halt; a set in the same cycle wins
      if (wr && wb_adr_i == sdorsp_pkg::ADR_STATUS && wb_sel_i[0] && wb_dat_i[sdorsp_pkg::STATUS_HALT_BIT]) begin
         halt_next = 1'b0;
      end
      if (cfg.halt_set) begin
         halt_next = 1'b1;
      end
   end

   // Register stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
         node_reg <= sdorsp_pkg::NODE_ID_RST;
         en_reg <= sdorsp_pkg::CTRL_EN_RST;
         halt_reg <= 1'b0;
         req_reg <= 16'h0000;
         err_reg <= 16'h0000;
      end else begin
         ack_reg <= ack_next;
         dat_reg <= dat_next;
         node_reg <= node_next;
         en_reg <= en_next;
         halt_reg <= halt_next;
         req_reg <= req_next;
         err_reg <= err_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign cfg.node_id = node_reg;
   assign cfg.enable = en_reg;
   assign cfg.halt = halt_reg;
endmodule
`default_nettype wire

/* core/sdorsp_responder.sv */
// Expedited request decoder and reply builder, top level
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Specifier 2 means write to index/subindex
// - One data byte: unused count 3, lowest byte
// - Writing 1 to halt object raises halt
// - Specifier 4 means query; data ignored
// - Query reply uses specifier 4, echoes index/subindex
// - Reply id is reply base plus node
// - 16-bit value: unused count 2, low bytes
// - Query 0x210D/0x02 returns battery tenths-of-volt
// - Raw count 400 means 40 volts
// - Byte0: specifier bits 7:4, unused bits 3:2
// - Good write replies specifier 6, no data
// - Unacceptable request replies specifier 8
module sdorsp_responder (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [10:0] rx_id,
   input wire logic [3:0] rx_dlc,
   input wire logic [63:0] rx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [10:0] tx_id,
   output logic [3:0] tx_dlc,
   output logic [63:0] tx_data,
   input wire logic [15:0] batt_decivolt,
   output logic halt
);
   sdorsp_cfg_if cfg ();

   // Register file on the bus
   sdorsp_wb_regs u_regs (
      .clk(clk),
      .rst_n(rst_n),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .cfg(cfg.regs)
   );

   sdorsp_pkg::sdorsp_state_e st_reg, st_next;  // Frame sequencer
   logic rx_ready_reg, rx_ready_next;           // Frame slot free
   logic [10:0] id_reg, id_next;                // Captured identifier
   logic [3:0] dlc_reg, dlc_next;               // Captured length
   logic [63:0] data_reg, data_next;            // Captured payload
   logic tx_valid_reg, tx_valid_next;           // Reply pending
   logic [10:0] tx_id_reg, tx_id_next;          // Reply identifier
   logic [63:0] tx_data_reg, tx_data_next;      // Reply payload
   logic halt_set_reg, halt_set_next;           // Halt request pulse
   logic req_inc_reg, req_inc_next;             // Accepted request pulse
   logic err_inc_reg, err_inc_next;             // Error reply pulse
   logic halt_out_reg, halt_out_next;           // Halt pin copy

   // Request fields, bytes numbered from the low end
   logic [3:0] cs;
   logic [1:0] unused;
   logic [15:0] index;
   logic [7:0] sub;
   logic [7:0] val0;
   logic [10:0] own_req_id;
   logic [7:0] rsp_cmd;
   logic [31:0] rsp_val;
   logic rsp_err;
   logic halt_req; // Decoded halt write, only used once a reply is due

   assign cs = data_reg[sdorsp_pkg::CS_MSB:sdorsp_pkg::CS_LSB];
   assign unused = data_reg[sdorsp_pkg::UNUSED_MSB:sdorsp_pkg::UNUSED_LSB];
   assign index = {data_reg[23:16], data_reg[15:8]};
   assign sub = data_reg[31:24];
   assign val0 = data_reg[39:32];
   assign own_req_id = sdorsp_pkg::REQ_BASE + {4'h0, cfg.node_id};

   // Reply decision for the captured request
   always_comb begin
      rsp_err = 1'b1;
      rsp_cmd = {sdorsp_pkg::CS_ERROR, 4'h0};
      rsp_val = 32'h00000000;
      halt_req = 1'b0;
      unique case (cs)
         // Writes: only the halt object, one byte, value 0 or 1
         sdorsp_pkg::CS_WRITE: begin
            if (index == sdorsp_pkg::HALT_INDEX && sub == sdorsp_pkg::HALT_SUB &&
                unused == sdorsp_pkg::UNUSED_ONE_BYTE &&
                (val0 == sdorsp_pkg::HALT_ON || val0 == sdorsp_pkg::HALT_OFF)) begin
               rsp_err = 1'b0;
               rsp_cmd = {sdorsp_pkg::CS_WRITE_OK, sdorsp_pkg::UNUSED_NONE, 2'h0};
               halt_req = (val0 == sdorsp_pkg::HALT_ON);
            end
         end
         // Queries: data bytes of the request are not looked at
         sdorsp_pkg::CS_QUERY: begin
            if (index == sdorsp_pkg::VOLT_INDEX && sub == sdorsp_pkg::VOLT_SUB) begin
               rsp_err = 1'b0;
               rsp_cmd = {sdorsp_pkg::CS_QUERY, sdorsp_pkg::UNUSED_U16, 2'h0};
               // Already in tenths of a volt, so 400 reads as 40 V
               rsp_val = {16'h0000, batt_decivolt};
            end
         end
         default: begin
            rsp_err = 1'b1; // Unknown specifier is refused
         end
      endcase
   end

   // Sequencer next state
   always_comb begin
      st_next = st_reg;
      rx_ready_next = rx_ready_reg;
      id_next = id_reg;
      dlc_next = dlc_reg;
      data_next = data_reg;
      tx_valid_next = tx_valid_reg;
      tx_id_next = tx_id_reg;
      tx_data_next = tx_data_reg;
      req_inc_next = 1'b0;
      err_inc_next = 1'b0;
      halt_set_next = 1'b0;
      // Pin follows the sticky halt, one edge behind the set pulse
      halt_out_next = cfg.halt | halt_set_reg;
      unique case (st_reg)
         // Take one whole frame, then close the slot while it is handled
         sdorsp_pkg::SDORSP_IDLE: begin
            if (rx_valid && rx_ready_reg) begin
               id_next = rx_id;
               dlc_next = rx_dlc;
               data_next = rx_data;
               rx_ready_next = 1'b0;
               st_next = sdorsp_pkg::SDORSP_DECODE;
            end else if (!rx_ready_reg) begin
               rx_ready_next = 1'b1; // Slot opens one cycle after reset release
            end
         end
         // Foreign or short frames are dropped silently
         sdorsp_pkg::SDORSP_DECODE: begin
            if (!cfg.enable || id_reg != own_req_id || dlc_reg != sdorsp_pkg::FRAME_DLC) begin
               rx_ready_next = 1'b1;
               st_next = sdorsp_pkg::SDORSP_IDLE;
            end else begin
               tx_id_next = sdorsp_pkg::RSP_BASE + {4'h0, cfg.node_id};
               tx_data_next = {rsp_val, sub, index[15:8], index[7:0], rsp_cmd};
               tx_valid_next = 1'b1;
               req_inc_next = 1'b1;
               err_inc_next = rsp_err;
               halt_set_next = halt_req;
               st_next = sdorsp_pkg::SDORSP_SEND;
            end
         end
         // Hold the reply until the CAN side takes it
         sdorsp_pkg::SDORSP_SEND: begin
            if (tx_ready && tx_valid_reg) begin
               tx_valid_next = 1'b0;
               rx_ready_next = 1'b1;
               st_next = sdorsp_pkg::SDORSP_IDLE;
            end
         end
         default: begin
            st_next = sdorsp_pkg::SDORSP_IDLE; // Illegal code recovers
            rx_ready_next = 1'b1;
            tx_valid_next = 1'b0;
         end
      endcase
   end

   // Sequencer registers; halt is only requested from DECODE
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= sdorsp_pkg::SDORSP_IDLE;
         rx_ready_reg <= 1'b0;
         id_reg <= 11'h000;
         dlc_reg <= 4'h0;
         data_reg <= 64'h0000000000000000;
         tx_valid_reg <= 1'b0;
         tx_id_reg <= 11'h000;
         tx_data_reg <= 64'h0000000000000000;
         halt_set_reg <= 1'b0;
         req_inc_reg <= 1'b0;
         err_inc_reg <= 1'b0;
         halt_out_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         rx_ready_reg <= rx_ready_next;
         id_reg <= id_next;
         dlc_reg <= dlc_next;
         data_reg <= data_next;
         tx_valid_reg <= tx_valid_next;
         tx_id_reg <= tx_id_next;
         tx_data_reg <= tx_data_next;
         halt_set_reg <= halt_set_next;
         req_inc_reg <= req_inc_next;
         err_inc_reg <= err_inc_next;
         halt_out_reg <= halt_out_next;
      end
   end

   assign cfg.halt_set = halt_set_reg;
   assign cfg.req_inc = req_inc_reg;
   assign cfg.err_inc = err_inc_reg;
   assign rx_ready = rx_ready_reg;
   assign tx_valid = tx_valid_reg;
   assign tx_id = tx_id_reg;
   assign tx_dlc = sdorsp_pkg::FRAME_DLC;
   assign tx_data = tx_data_reg;
   assign halt = halt_out_reg;
endmodule
`default_nettype wire

/* testbench/sdorsp_sva.sv */
// Port-level assertion checker for the request responder
`timescale 1ns/1ns
`default_nettype none
module sdorsp_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic [63:0] rx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [10:0] tx_id,
   input wire logic [3:0] tx_dlc,
   input wire logic [63:0] tx_data,
   input wire logic halt
);
   // One domain, so one clock and one reset for all
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Frame handed over by the client
   sequence s_take; rx_valid && rx_ready; endsequence
   // One-byte write of 1 to the halt object
   sequence s_halt_take; s_take ##0 (rx_data[39:0] == 40'h01_0020_0C2C); endsequence
   // Reply on offer, by specifier
   sequence s_query_rsp; tx_valid && tx_data[7:4] == sdorsp_pkg::CS_QUERY; endsequence
   sequence s_ok_rsp; tx_valid && tx_data[7:0] == 8'h60; endsequence
   sequence s_err_rsp; tx_valid && tx_data[7:4] == sdorsp_pkg::CS_ERROR; endsequence
   a_take_blocks: assert property (s_take |=> !rx_ready) else $error("ready stayed high after a take");
   a_reply_late: assert property ($rose(tx_valid) |-> $past(rx_valid && rx_ready, 2))
      else $error("reply not two cycles after a take");
   a_reply_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_id))
      else $error("reply changed before handoff");
   a_dlc_fixed: assert property (tx_dlc == sdorsp_pkg::FRAME_DLC) else $error("reply length not eight");
   a_reply_id: assert property (tx_valid |-> tx_id[10:7] == sdorsp_pkg::RSP_BASE[10:7])
      else $error("reply identifier base wrong");
   a_query_fmt: assert property (s_query_rsp |-> tx_data[3:0] == 4'h8 && tx_data[63:48] == 16'h0000
      && tx_data[31:8] == {sdorsp_pkg::VOLT_SUB, sdorsp_pkg::VOLT_INDEX}) else $error("query reply malformed");
   a_write_ok: assert property (s_ok_rsp |-> tx_data[63:32] == 32'h0
      && tx_data[31:8] == {sdorsp_pkg::HALT_SUB, sdorsp_pkg::HALT_INDEX}) else $error("write reply malformed");
   a_error_fmt: assert property (s_err_rsp |-> tx_data[3:0] == 4'h0 && tx_data[63:32] == 32'h0)
      else $error("error reply malformed");
   a_halt_sets: assert property (s_halt_take ##2 s_ok_rsp |-> ##1 halt) else $error("halt not raised");
   // Pin trails the status bit by one edge, so the clearing write lies two edges back
   a_halt_sticky: assert property ($fell(halt) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i, 2))
      else $error("halt dropped without software");
endmodule
bind sdorsp_responder sdorsp_sva i_sva (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data), .halt(halt));
`default_nettype wire

/* testbench/sdorsp_client.sv */
// Behavioural model of the remote client node
`timescale 1ns/1ns
`default_nettype none
module sdorsp_client (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic send,
   input wire logic [10:0] f_id,
   input wire logic [63:0] f_data,
   input wire logic [3:0] delay,
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [10:0] rx_id,
   output logic [3:0] rx_dlc,
   output logic [63:0] rx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [10:0] tx_id,
   input wire logic [63:0] tx_data,
   output logic got,
   output logic [10:0] rep_id,
   output logic [63:0] rep_data
);
   logic [3:0] wait_cnt; // Cycles the reply has waited
   // Offer frames, release them scrambled, accept replies late on request
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_valid <= 1'b0;
         rx_id <= 11'h0;
         rx_dlc <= 4'h0;
         rx_data <= 64'h0;
         tx_ready <= 1'b0;
         wait_cnt <= 4'h0;
         got <= 1'b0;
         rep_id <= 11'h0;
         rep_data <= 64'h0;
      end else begin
         if (rx_valid && rx_ready) begin
            // Released lines must not keep the old frame
            rx_valid <= 1'b0;
            rx_id <= ~rx_id;
            rx_data <= ~rx_data;
         end else if (send) begin
            rx_valid <= 1'b1;
            rx_id <= f_id;
            rx_dlc <= 4'h8;
            rx_data <= f_data;
         end
         tx_ready <= tx_valid && !tx_ready && (wait_cnt >= delay);
         wait_cnt <= (tx_valid && !tx_ready) ? wait_cnt + 4'h1 : 4'h0;
         got <= tx_valid && tx_ready;
         rep_id <= tx_id;
         rep_data <= tx_data;
      end
   end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the request responder
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk = 1'b0; // 20 MHz system clock
   logic rst_n = 1'b0; // Reset, active low
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
   logic wb_ack, rx_valid, rx_ready, tx_valid, tx_ready, halt, got;
   logic [10:0] rx_id, tx_id, rep_id;
   logic [3:0] rx_dlc, tx_dlc;
   logic [63:0] rx_data, tx_data, rep_data;
   logic [15:0] batt = 16'h0190; // Forty volts in tenths
   logic send = 1'b0;
   logic [3:0] delay = 4'h0; // Client slowness
   logic [10:0] f_id = 11'h0;
   logic [63:0] f_data = 64'h0;
   int mismatches = 0, total_checks = 0, cycles = 0;
   always #25 clk = ~clk;
   sdorsp_responder i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(4'hF), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data),
      .batt_decivolt(batt), .halt(halt));
   sdorsp_client i_cli (.clk(clk), .rst_n(rst_n), .send(send), .f_id(f_id), .f_data(f_data), .delay(delay),
      .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_data(tx_data), .got(got),
      .rep_id(rep_id), .rep_data(rep_data));
   // Compare and count
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Classic single Wishbone cycle, read data lands in rd
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_wdat <= dat;
      @(posedge clk);
      // Wait for the ack; the hang guard ends this wait if none comes
      while (wb_ack !== 1'b1) begin
         @(posedge clk);
      end
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask
   // Offer one frame, then watch a bounded window for a reply
   task automatic frame(input logic [10:0] id, input logic [63:0] data, input logic owed,
      input logic [10:0] eid, input logic [63:0] edata);
      int n;
      logic seen;
      n = 0;
      seen = 1'b0;
      f_id <= id;
      f_data <= data;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      while (n < 30) begin
         @(posedge clk);
         n++;
         if (got === 1'b1) begin
            seen = 1'b1;
            check({53'h0, rep_id}, {53'h0, eid});
            check(rep_data, edata);
         end
      end
      check({63'h0, seen}, {63'h0, owed});
   endtask
   // Counts, then the verdict
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Hang guard, well above the few hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Register reset values, one unmapped word
      wb(1'b0, sdorsp_pkg::ADR_CTRL, 32'h0);
      check(rd, 32'h0000_0101);
      wb(1'b0, sdorsp_pkg::ADR_STATUS, 32'h0);
      check(rd, 32'h0);
      wb(1'b0, 8'h0C, 32'h0);
      check(rd, 32'h0);
      $display("test registers done");
      // Node twelve, halt write, slow client
      wb(1'b1, sdorsp_pkg::ADR_CTRL, 32'h0000_010C);
      delay <= 4'h3;
      frame(11'h60C, 64'h0000_0001_0020_0C2C, 1'b1, 11'h58C, 64'h0000_0000_0020_0C60);
      check({63'h0, halt}, 64'h1);
      $display("test halt done");
      // Battery query with junk data, prompt client
      delay <= 4'h0;
      frame(11'h60C, 64'h0000_000A_0221_0D48, 1'b1, 11'h58C, 64'h0000_0190_0221_0D48);
      $display("test query done");
      // Clear halt, then a halt write to another node
      wb(1'b1, sdorsp_pkg::ADR_STATUS, 32'h1);
      @(posedge clk); // Pin copy trails the status bit by one edge
      check({63'h0, halt}, 64'h0);
      frame(11'h601, 64'h0000_0001_0020_0C2C, 1'b0, 11'h0, 64'h0);
      check({63'h0, halt}, 64'h0);
      $display("test foreign done");
      // Unknown object and write to a read-only one
      frame(11'h60C, 64'h0000_0000_0220_0340, 1'b1, 11'h58C, 64'h0000_0000_0220_0380);
      frame(11'h60C, 64'h0000_0001_0221_0D2C, 1'b1, 11'h58C, 64'h0000_0000_0221_0D80);
      $display("test errors done");
      // Disabled responder stays silent
      wb(1'b1, sdorsp_pkg::ADR_CTRL, 32'h0000_000C);
      frame(11'h60C, 64'h0000_0001_0020_0C2C, 1'b0, 11'h0, 64'h0);
      check({63'h0, halt}, 64'h0);
      $display("test disable done");
      // Counters: four replies so far, two of them errors
      wb(1'b0, sdorsp_pkg::ADR_COUNT, 32'h0);
      check(rd, 32'h0002_0004);
      $display("test counters done");
      complete_run();
   end
endmodule
`default_nettype wire
